// [src/wmh_dev.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wmh_cfg.svh"

module wmh_fifo #(
  parameter int W = `WMH_BYTE_W,
  parameter int D = `WMH_FIFO_D
) (
  input  wire logic         clk,       // System clock
  input  wire logic         rstn,      // Async reset, active low
  input  wire logic         flush,     // Drop all contents
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Room available
  input  wire logic [W-1:0] in_data,   // Write data
  output logic              out_valid, // Data available
  input  wire logic         out_ready, // Read accept
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
  } wmh_fifo_s;
  wmh_fifo_s s, n;
  logic      wr, rd;

  assign in_ready  = (s.cnt != CW'(D));
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rp];
  assign wr        = in_valid & in_ready;
  assign rd        = out_valid & out_ready;

  // Pointers wrap explicitly at D-1, so any depth of two or more works
  always_comb begin
    n = s;
    if (wr) begin
      n.mem[s.wp] = in_data;
      n.wp        = (s.wp == AW'(D - 1)) ? '0 : s.wp + 1'b1;
    end
    if (rd)
      n.rp = (s.rp == AW'(D - 1)) ? '0 : s.rp + 1'b1;
    n.cnt = s.cnt + CW'(wr) - CW'(rd);
    if (flush) begin
      n.wp  = '0;
      n.rp  = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) s <= '0;
    else       s <= n;
  end
endmodule // wmh_fifo

module wmh_dev #(
  parameter logic [`WMH_CNT_W-1:0] RELEASE_CYC = `WMH_CNT_W'(`WMH_RELEASE_CYC)
) (
  input  wire logic                    clk,            // System clock
  input  wire logic                    rstn,           // Async reset, active low
  wmh_if.dev                           link,           // Pins toward host
  input  wire logic                    supply_ok,      // Supply within range
  input  wire logic                    power_save_enable, // Power save allowed
  input  wire logic                    dtim_tick,      // Beacon wake pulse
  input  wire logic                    traffic_queued, // Data waits at access point
  input  wire logic                    radio_rx_busy,  // Radio receiving
  input  wire logic                    radio_tx_busy,  // Radio transmitting
  input  wire logic                    load_valid,     // Byte for host offered
  output logic                         load_ready,     // Byte accepted
  input  wire logic [`WMH_BYTE_W-1:0]  load_data,      // Byte for host
  output logic [`WMH_BYTE_W-1:0]       rx_data,        // Byte from host
  output logic                         rx_valid,       // Byte from host pulse
  output logic                         xfer_done,      // CS rise pulse
  output logic                         regulators_on,  // Core supplies enabled
  output logic                         core_in_reset,  // Core held in reset
  output wmh_pkg::wmh_dev_state_e      power_state     // Current power state
);
  wmh_pkg::wmh_dev_s         s, n;
  logic                      rise, fall, cs_fall, cs_rise, op, pop;
  logic                      f_in_ready, f_valid;
  logic [`WMH_BYTE_W-1:0]    f_data;

  wmh_fifo #(.W(`WMH_BYTE_W), .D(`WMH_FIFO_D)) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .flush     (~op),
    .in_valid  (load_valid & op),
    .in_ready  (f_in_ready),
    .in_data   (load_data),
    .out_valid (f_valid),
    .out_ready (pop),
    .out_data  (f_data)
  );

  assign rise    = s.sck_s & ~s.sck_q;
  assign fall    = ~s.sck_s & s.sck_q;
  assign cs_fall = ~s.cs_s & s.cs_q;
  assign cs_rise = s.cs_s & ~s.cs_q;
  assign op      = (s.st == wmh_pkg::DS_STANDBY) || (s.st == wmh_pkg::DS_PSAVE) ||
                   (s.st == wmh_pkg::DS_RX) || (s.st == wmh_pkg::DS_TX);

  // Power state machine and SPI slave in one next-state block
  always_comb begin
    n          = s;
    pop        = 1'b0;
    n.rx_valid = 1'b0;
    n.done     = 1'b0;
    // Pins are asynchronous to clk, two stages before use
    n.sck_m  = link.sck;
    n.sck_s  = s.sck_m;
    n.sck_q  = s.sck_s;
    n.cs_m   = link.cs_n;
    n.cs_s   = s.cs_m;
    n.cs_q   = s.cs_s;
    n.mosi_m = link.mosi;
    n.mosi_s = s.mosi_m;
    n.deep_m = link.deep_off;
    n.deep_s = s.deep_m;
    n.hrst_m = link.reset_n;
    n.hrst_s = s.hrst_m;
    case (s.st)
      wmh_pkg::DS_DEEP: begin
        n.st = wmh_pkg::DS_POR;
      end
      wmh_pkg::DS_POR: begin
        if (supply_ok) n.st = wmh_pkg::DS_RESET;
      end
      wmh_pkg::DS_RESET: begin
        if (s.hrst_s) begin
          n.st  = wmh_pkg::DS_RELEASE;
          n.cnt = '0;
        end
      end
      wmh_pkg::DS_RELEASE: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == RELEASE_CYC - 1'b1) n.st = wmh_pkg::DS_STANDBY;
      end
      // Stand-by is where the device rests while power save is off; host CS low or radio transmit brings power save back to it
      wmh_pkg::DS_STANDBY: begin
        if (radio_tx_busy)      n.st = wmh_pkg::DS_TX;
        else if (radio_rx_busy) n.st = wmh_pkg::DS_RX;
        else if (power_save_enable && !f_valid && !s.loaded && s.cs_s)
          n.st = wmh_pkg::DS_PSAVE;
      end
      wmh_pkg::DS_PSAVE: begin
        // Wake is immediate, well inside the latency budget
        if (dtim_tick && traffic_queued) n.st = wmh_pkg::DS_RX;
        else if (!s.cs_s || radio_tx_busy) n.st = wmh_pkg::DS_STANDBY;
      end
      wmh_pkg::DS_RX: begin
        if (!radio_rx_busy) n.st = wmh_pkg::DS_STANDBY;
      end
      wmh_pkg::DS_TX: begin
        if (!radio_tx_busy) n.st = wmh_pkg::DS_STANDBY;
      end
      default: n.st = wmh_pkg::DS_DEEP;
    endcase

    // Slave shifter: sample on rise, shift on fall after the first rise
    if (op) begin
      if (cs_fall) begin
        n.started = 1'b0;
        n.bits    = `WMH_FIRST_BIT;
        // A byte left over from a short block is kept, not popped again
        if (!s.loaded) begin
          pop      = f_valid;
          n.tx_sh  = f_valid ? f_data : `WMH_IDLE_BYTE;
          n.loaded = f_valid;
        end
      end else if (!s.cs_s) begin
        if (rise) begin
          n.rx_sh   = {s.rx_sh[`WMH_BYTE_W-2:0], s.mosi_s};
          n.bits    = s.bits + 1'b1;
          n.started = 1'b1;
          if (s.bits == `WMH_LAST_BIT) begin
            n.rx_data  = {s.rx_sh[`WMH_BYTE_W-2:0], s.mosi_s};
            n.rx_valid = 1'b1;
            n.loaded   = 1'b0;
          end
        end else if (fall && s.started) begin
          if (s.bits == `WMH_FIRST_BIT) begin
            pop      = f_valid;
            n.tx_sh  = f_valid ? f_data : `WMH_IDLE_BYTE;
            n.loaded = f_valid;
          end else begin
            n.tx_sh = {s.tx_sh[`WMH_BYTE_W-2:0], 1'b0};
          end
        end
      end
      if (cs_rise) begin
        n.done    = 1'b1;
        n.started = 1'b0;
      end
    end

    // Overrides in falling priority: deep off, supply, host reset
    if (s.deep_s) begin
      n.st      = wmh_pkg::DS_DEEP;
      n.cnt     = '0;
      n.started = 1'b0;
      n.bits    = `WMH_FIRST_BIT;
      n.tx_sh   = '0;
      n.rx_sh   = '0;
      n.rx_data = '0;
      n.loaded  = 1'b0;
    end else if (!supply_ok) begin
      n.st     = wmh_pkg::DS_POR;
      n.loaded = 1'b0;
    end else if (!s.hrst_s && s.st != wmh_pkg::DS_DEEP && s.st != wmh_pkg::DS_POR) begin
      n.st     = wmh_pkg::DS_RESET;
      n.loaded = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s      <= '0;
      s.st   <= wmh_pkg::DS_POR;
      s.cs_m <= 1'b1;
      s.cs_s <= 1'b1;
      s.cs_q <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.miso    = s.tx_sh[`WMH_BYTE_W-1];
  assign link.attn_o  = 1'b0;
  // Pull low while a byte waits in the buffer or the shifter
  assign link.attn_oe = op & (s.loaded | f_valid);
  assign load_ready   = f_in_ready & op;
  assign rx_data      = s.rx_data;
  assign rx_valid     = s.rx_valid;
  assign xfer_done    = s.done;
  assign regulators_on = (s.st != wmh_pkg::DS_DEEP);
  assign core_in_reset = (s.st == wmh_pkg::DS_POR) || (s.st == wmh_pkg::DS_RESET) ||
                         (s.st == wmh_pkg::DS_RELEASE);
  assign power_state  = s.st;
endmodule // wmh_dev
`default_nettype wire

// [pkg/wmh_cfg.svh]
// Summary of operation
// - Deep-off pin high turns core regulators off
// - Hold reset until supply is good
// - Host waits 1 ms after deep-off release
// - About 300 ms release from reset, both watch
// - Deep off keeps no state, fresh restart
// - Only host enters and leaves deep off
// - Host wait covers bulk capacitance charge
// - Power save entered once activity finishes
// - Wake on DTIM, fetch queued data or sleep
// - Leave power save with low latency
// - Chip select high in deep off
// - Stand-by only an internal transition state; device rests there while power save is off
// - Active has receive and transmit substates
// - Attention low while data waits for host
// - Attention released once data shifted out
// - Host SCK no faster than 25 MHz
// - Modes 0 and 3, sample on rising edge
// - Bytes shifted most significant bit first
// - Chip select toggled per block, never stuck
// - CS fall starts, CS rise ends transfer
// - Chip select always driven by host
// - Attention is open drain with pull-up
`ifndef WMH_CFG_SVH
`define WMH_CFG_SVH
`define WMH_CLK_MHZ       250
`define WMH_SETTLE_MS     1
`define WMH_RELEASE_MS    300
`define WMH_SETTLE_CYC    (`WMH_SETTLE_MS * `WMH_CLK_MHZ * 1000)
`define WMH_RELEASE_CYC   (`WMH_RELEASE_MS * `WMH_CLK_MHZ * 1000)
`define WMH_CNT_W         27
`define WMH_SCK_MAX_MHZ   25
`define WMH_SCK_HALF_MIN  ((`WMH_CLK_MHZ + 2 * `WMH_SCK_MAX_MHZ - 1) / (2 * `WMH_SCK_MAX_MHZ))
`define WMH_SCK_HALF      (`WMH_SCK_HALF_MIN + 1)
`define WMH_HALF_W        4
`define WMH_BYTE_W        8
`define WMH_BIT_W         3
`define WMH_LAST_BIT      3'h7
`define WMH_FIRST_BIT     3'h0
`define WMH_LEN_W         4
`define WMH_FIFO_D        16
`define WMH_IDLE_BYTE     8'h00
`endif

// [pkg/wmh_pkg.sv]
`default_nettype none
`include "wmh_cfg.svh"
package wmh_pkg;
  typedef enum logic [2:0] {
    DS_DEEP, DS_POR, DS_RESET, DS_RELEASE, DS_STANDBY, DS_PSAVE, DS_RX, DS_TX
  } wmh_dev_state_e;

  typedef enum logic [3:0] {
    HS_DEEP, HS_SETTLE, HS_RELEASE, HS_READY, HS_LOAD, HS_LOW, HS_HIGH, HS_GAP, HS_HOLD
  } wmh_host_state_e;

  typedef struct packed {
    wmh_dev_state_e           st;
    logic [`WMH_CNT_W-1:0]    cnt;
    logic                     sck_m, sck_s, sck_q;
    logic                     cs_m, cs_s, cs_q;
    logic                     mosi_m, mosi_s;
    logic                     deep_m, deep_s;
    logic                     hrst_m, hrst_s;
    logic                     started;
    logic [`WMH_BIT_W-1:0]    bits;
    logic [`WMH_BYTE_W-1:0]   tx_sh;
    logic [`WMH_BYTE_W-1:0]   rx_sh;
    logic                     loaded;
    logic [`WMH_BYTE_W-1:0]   rx_data;
    logic                     rx_valid;
    logic                     done;
  } wmh_dev_s;

  typedef struct packed {
    wmh_host_state_e          st;
    logic [`WMH_CNT_W-1:0]    cnt;
    logic [`WMH_HALF_W-1:0]   half;
    logic [`WMH_BIT_W-1:0]    bits;
    logic [`WMH_LEN_W-1:0]    len;
    logic [`WMH_BYTE_W-1:0]   tx_sh;
    logic [`WMH_BYTE_W-1:0]   rx_sh;
    logic                     sck;
    logic                     cs_n;
    logic                     deep_off;
    logic                     reset_n;
    logic                     miso_m, miso_s;
    logic                     attn_m, attn_s;
    logic [`WMH_BYTE_W-1:0]   rx_data;
    logic                     rx_valid;
    logic                     done;
  } wmh_host_s;
endpackage
`default_nettype wire

// [pkg/wmh_if.sv]
`timescale 1ns/10ps
`default_nettype none
interface wmh_if;
  logic sck;       // SPI clock from host
  logic cs_n;      // Chip select, active low
  logic mosi;      // Host to device data
  logic miso;      // Device to host data
  logic deep_off;  // High puts device in deep off
  logic reset_n;   // Device reset from host
  logic attn_o;    // Attention drive level
  logic attn_oe;   // Attention pull-down enable
  logic attn_n;    // Resolved attention line

  // Open drain with board pull-up
  assign attn_n = attn_oe ? attn_o : 1'b1;

  modport dev  (input sck, cs_n, mosi, deep_off, reset_n, output miso, attn_o, attn_oe);
  modport host (output sck, cs_n, mosi, deep_off, reset_n, input miso, attn_n);
endinterface
`default_nettype wire

// [src/wmh_host.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wmh_cfg.svh"

module wmh_host #(
  parameter logic [`WMH_CNT_W-1:0]  SETTLE_CYC  = `WMH_CNT_W'(`WMH_SETTLE_CYC),
  parameter logic [`WMH_CNT_W-1:0]  RELEASE_CYC = `WMH_CNT_W'(`WMH_RELEASE_CYC),
  parameter logic [`WMH_HALF_W-1:0] SCK_HALF    = `WMH_HALF_W'(`WMH_SCK_HALF)
) (
  input  wire logic                    clk,          // System clock
  input  wire logic                    rstn,         // Async reset, active low
  wmh_if.host                          link,         // Pins toward device
  input  wire logic                    power_up,     // High to run, low for deep off
  input  wire logic                    start,        // Begin a block
  input  wire logic [`WMH_LEN_W-1:0]   len_m1,       // Bytes in block minus one
  input  wire logic                    tx_valid,     // Byte to send offered
  output logic                         tx_ready,     // Byte to send taken
  input  wire logic [`WMH_BYTE_W-1:0]  tx_data,      // Byte to send
  output logic [`WMH_BYTE_W-1:0]       rx_data,      // Byte received
  output logic                         rx_valid,     // Byte received pulse
  output logic                         ready,        // Startup done, idle
  output logic                         xfer_done,    // Block finished pulse
  output logic                         attn_pending  // Device has data
);
  wmh_pkg::wmh_host_s s, n;
  logic               half_end;

  assign half_end = (s.half == SCK_HALF - 1'b1);

  // Startup sequencer and mode 0 master in one next-state block
  always_comb begin
    n          = s;
    n.rx_valid = 1'b0;
    n.done     = 1'b0;
    n.miso_m   = link.miso;
    n.miso_s   = s.miso_m;
    n.attn_m   = link.attn_n;
    n.attn_s   = s.attn_m;
    case (s.st)
      wmh_pkg::HS_DEEP: begin
        if (power_up) begin
          n.deep_off = 1'b0;
          n.cnt      = '0;
          n.st       = wmh_pkg::HS_SETTLE;
        end
      end
      // Lengthen SETTLE_CYC when the supply charges the bulk caps slowly
      wmh_pkg::HS_SETTLE: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == SETTLE_CYC - 1'b1) begin
          n.reset_n = 1'b1;
          n.cnt     = '0;
          n.st      = wmh_pkg::HS_RELEASE;
        end
      end
      wmh_pkg::HS_RELEASE: begin
        n.cnt = s.cnt + 1'b1;
        if (s.cnt == RELEASE_CYC - 1'b1) n.st = wmh_pkg::HS_READY;
      end
      wmh_pkg::HS_READY: begin
        if (start) begin
          n.len  = len_m1;
          n.cs_n = 1'b0;
          n.st   = wmh_pkg::HS_LOAD;
        end
      end
      // Clock waits low between bytes until the next byte is offered
      wmh_pkg::HS_LOAD: begin
        if (tx_valid) begin
          n.tx_sh = tx_data;
          n.bits  = `WMH_FIRST_BIT;
          n.half  = '0;
          n.st    = wmh_pkg::HS_LOW;
        end
      end
      wmh_pkg::HS_LOW: begin
        n.half = s.half + 1'b1;
        if (half_end) begin
          n.half = '0;
          n.sck  = 1'b1;
          n.st   = wmh_pkg::HS_HIGH;
        end
      end
      // Sample late in the high phase, well after the device shifted
      wmh_pkg::HS_HIGH: begin
        n.half = s.half + 1'b1;
        if (half_end) begin
          n.half  = '0;
          n.sck   = 1'b0;
          n.rx_sh = {s.rx_sh[`WMH_BYTE_W-2:0], s.miso_s};
          n.tx_sh = {s.tx_sh[`WMH_BYTE_W-2:0], 1'b0};
          n.bits  = s.bits + 1'b1;
          n.st    = wmh_pkg::HS_LOW;
          if (s.bits == `WMH_LAST_BIT) begin
            n.rx_data  = {s.rx_sh[`WMH_BYTE_W-2:0], s.miso_s};
            n.rx_valid = 1'b1;
            if (s.len == '0) begin
              n.st = wmh_pkg::HS_GAP;
            end else begin
              n.len = s.len - 1'b1;
              n.st  = wmh_pkg::HS_LOAD;
            end
          end
        end
      end
      wmh_pkg::HS_GAP: begin
        n.half = s.half + 1'b1;
        if (half_end) begin
          n.half = '0;
          n.cs_n = 1'b1;
          n.st   = wmh_pkg::HS_HOLD;
        end
      end
      // Keep chip select high long enough for the device to see it
      wmh_pkg::HS_HOLD: begin
        n.half = s.half + 1'b1;
        if (half_end) begin
          n.half = '0;
          n.done = 1'b1;
          n.st   = wmh_pkg::HS_READY;
        end
      end
      default: n.st = wmh_pkg::HS_DEEP;
    endcase

    // Deep off is entered only on the host's own decision
    if (!power_up) begin
      n.st       = wmh_pkg::HS_DEEP;
      n.deep_off = 1'b1;
      n.reset_n  = 1'b0;
      n.cs_n     = 1'b1;
      n.sck      = 1'b0;
      n.half     = '0;
      n.cnt      = '0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s          <= '0;
      s.st       <= wmh_pkg::HS_DEEP;
      s.cs_n     <= 1'b1;
      s.deep_off <= 1'b1;
      s.attn_m   <= 1'b1;
      s.attn_s   <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign link.sck      = s.sck;
  assign link.cs_n     = s.cs_n;
  assign link.mosi     = s.tx_sh[`WMH_BYTE_W-1];
  assign link.deep_off = s.deep_off;
  assign link.reset_n  = s.reset_n;
  assign tx_ready      = (s.st == wmh_pkg::HS_LOAD);
  assign rx_data       = s.rx_data;
  assign rx_valid      = s.rx_valid;
  assign ready         = (s.st == wmh_pkg::HS_READY);
  assign xfer_done     = s.done;
  assign attn_pending  = ~s.attn_s;
endmodule // wmh_host
`default_nettype wire

// [tb/wmh_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module wmh_monitor (
  input wire logic clk,      // System clock
  input wire logic rstn,     // Async reset, active low
  input wire logic sck,      // SPI clock
  input wire logic cs_n,     // Chip select
  input wire logic mosi,     // Host data
  input wire logic miso,     // Device data
  input wire logic deep_off, // Deep off pin
  input wire logic reset_n,  // Device reset pin
  input wire logic attn_o,   // Attention level
  input wire logic attn_oe   // Attention enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Startup steps: the host keeps the device quiet while it settles
  sequence s_quiet;
    (!reset_n && cs_n)[*8];
  endsequence
  sequence s_no_xfer;
    cs_n[*8];
  endsequence

  property p_cs_deep; deep_off |-> cs_n; endproperty
  a_cs_deep: assert property (p_cs_deep)
    else $error("chip select low in deep off");
  property p_attn_low; attn_oe |-> !attn_o; endproperty
  a_attn_low: assert property (p_attn_low)
    else $error("attention driven high");
  // Attention may only drop by a transfer or by a reset of the device
  property p_attn_drop; $fell(attn_oe) |-> !cs_n || deep_off || !reset_n; endproperty
  a_attn_drop: assert property (p_attn_drop)
    else $error("attention dropped outside a transfer");
  property p_sck_idle; cs_n |-> !sck; endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("clock not idle low");
  // Five cycles of 4 ns per half keep the clock at 25 MHz or below
  property p_sck_high; $rose(sck) |-> sck[*5]; endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("clock high phase short");
  property p_sck_low; $fell(sck) |-> (!sck)[*5]; endproperty
  a_sck_low: assert property (p_sck_low)
    else $error("clock low phase short");
  property p_settle; $fell(deep_off) |-> s_quiet; endproperty
  a_settle: assert property (p_settle)
    else $error("reset released too soon");
  property p_release; $rose(reset_n) |-> s_no_xfer; endproperty
  a_release: assert property (p_release)
    else $error("transfer during release");
  property p_cs_pulse; $fell(cs_n) |-> ##[1:1000] cs_n; endproperty
  a_cs_pulse: assert property (p_cs_pulse)
    else $error("chip select stuck low");
  property p_cs_gap; $rose(cs_n) |-> cs_n[*3]; endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("chip select gap short");
  property p_mosi_hold; sck |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved while clock high");
  property p_miso_hold; sck && !cs_n |-> $stable(miso); endproperty
  a_miso_hold: assert property (p_miso_hold)
    else $error("device data moved while clock high");
endmodule // wmh_monitor
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wmh_cfg.svh"
module tb_top;
  logic       clk, rstn, power_up, start, tx_valid, tx_ready, ready, h_done, attn_pending;
  logic       supply_ok, power_save_enable, dtim_tick, traffic_queued, rx_busy, tx_busy;
  logic       load_valid, load_ready, d_rx_valid, h_rx_valid, d_done, regulators_on;
  logic       core_in_reset, sck_q;
  logic [3:0] len_m1;
  logic [7:0] tx_data, load_data, h_rx_data, d_rx_data, w_sh;
  logic [7:0] h_q[$], d_q[$], w_q[$];
  int         n_mismatch = 0, compares = 0, n_ddone = 0, n_hdone = 0, w_cnt = 0;
  wmh_pkg::wmh_dev_state_e power_state;

  wmh_if link ();
  // Short counts keep the run brief; device release stays below the host's
  wmh_host #(.SETTLE_CYC(`WMH_CNT_W'(20)), .RELEASE_CYC(`WMH_CNT_W'(40))) wmh_host_i (
    .clk(clk), .rstn(rstn), .link(link), .power_up(power_up), .start(start),
    .len_m1(len_m1), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_data(h_rx_data), .rx_valid(h_rx_valid), .ready(ready), .xfer_done(h_done),
    .attn_pending(attn_pending));
  wmh_dev #(.RELEASE_CYC(`WMH_CNT_W'(30))) wmh_dev_i (
    .clk(clk), .rstn(rstn), .link(link), .supply_ok(supply_ok),
    .power_save_enable(power_save_enable), .dtim_tick(dtim_tick),
    .traffic_queued(traffic_queued), .radio_rx_busy(rx_busy),
    .radio_tx_busy(tx_busy), .load_valid(load_valid), .load_ready(load_ready),
    .load_data(load_data), .rx_data(d_rx_data), .rx_valid(d_rx_valid), .xfer_done(d_done),
    .regulators_on(regulators_on), .core_in_reset(core_in_reset), .power_state(power_state));
  wmh_monitor wmh_monitor_i (
    .clk(clk), .rstn(rstn), .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .deep_off(link.deep_off), .reset_n(link.reset_n),
    .attn_o(link.attn_o), .attn_oe(link.attn_oe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Collect bytes at both user sides and straight off the wire
  always @(posedge clk) begin
    if (h_rx_valid === 1'b1) h_q.push_back(h_rx_data);
    if (d_rx_valid === 1'b1) d_q.push_back(d_rx_data);
    if (d_done === 1'b1) n_ddone++;
    if (h_done === 1'b1) n_hdone++;
    sck_q <= link.sck;
    if (link.cs_n !== 1'b0) w_cnt = 0;
    else if (link.sck === 1'b1 && sck_q === 1'b0) begin
      w_sh = {w_sh[6:0], link.mosi};
      w_cnt++;
      if (w_cnt == 8) w_q.push_back(w_sh);
      if (w_cnt == 8) w_cnt = 0;
    end
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_state(string what, wmh_pkg::wmh_dev_state_e exp,
                           wmh_pkg::wmh_dev_state_e got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %s seen %s", what, exp.name(), got.name());
    end
  endtask

  task automatic fail_wait(string what);
    n_mismatch++;
    $display("[ERR] %s expected done seen timeout", what);
    end_of_test();
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    while (ready !== 1'b1) begin
      @(negedge clk);
      k++;
      if (k > 400) fail_wait("ready");
    end
  endtask

  task automatic wait_state(wmh_pkg::wmh_dev_state_e s, int lim);
    int k;
    k = 0;
    while (power_state !== s && k < lim) begin
      @(negedge clk);
      k++;
    end
    chk_state("power state", s, power_state);
  endtask

  // Valid stays up between calls so no step drives it twice
  task automatic dev_load(logic [7:0] b, output bit ok);
    int k;
    load_data = b;
    load_valid = 1'b1;
    k = 0;
    while (load_ready !== 1'b1 && k < 4) begin
      @(negedge clk);
      k++;
    end
    ok = (load_ready === 1'b1);
    @(negedge clk);
  endtask

  // One block from the host side, stalling the sender before byte 2
  task automatic host_block(int n, logic [7:0] base);
    int k;
    start = 1'b1;
    len_m1 = 4'(n - 1);
    @(negedge clk);
    start = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == 2) tx_valid = 1'b0;
      if (i == 2) repeat (120) @(negedge clk);
      tx_data = base + 8'(i);
      tx_valid = 1'b1;
      k = 0;
      while (tx_ready !== 1'b1) begin
        @(negedge clk);
        k++;
        if (k > 400) fail_wait("tx_ready");
      end
      @(negedge clk);
    end
    tx_valid = 1'b0;
    wait_ready();
  endtask

  task automatic t_startup();
    power_up = 1'b1;
    wait_ready();
    chk("reset_n", 1, link.reset_n);
    repeat (40) @(negedge clk);
    chk("core reset no supply", 1, core_in_reset);
    supply_ok = 1'b1;
    repeat (20) @(negedge clk);
    chk("core reset in release", 1, core_in_reset);
    wait_state(wmh_pkg::DS_STANDBY, 60);
    chk("core reset", 0, core_in_reset);
    chk("regulators", 1, regulators_on);
    $display("test startup done");
  endtask

  task automatic t_fifo();
    int n;
    bit ok;
    n = 0;
    ok = 1'b1;
    chk("attn idle", 0, attn_pending);
    while (ok && n < 20) begin
      dev_load(8'(n * 37 + 5), ok);
      if (ok) n++;
    end
    load_valid = 1'b0;
    chk("fifo depth", 16, 8'(n));
    repeat (4) @(negedge clk);
    chk("attn pending", 1, attn_pending);
    host_block(8, 8'hA0);
    chk("attn half", 1, attn_pending);
    host_block(8, 8'hA8);
    repeat (4) @(negedge clk);
    chk("attn released", 0, attn_pending);
    chk("cs rise count", 2, 8'(n_ddone));
    chk("host done count", 2, 8'(n_hdone));
    for (int i = 0; i < 16; i++) begin
      chk("host rx", 8'(i * 37 + 5), h_q[i]);
      chk("device rx", 8'hA0 + 8'(i), d_q[i]);
      chk("wire mosi", 8'hA0 + 8'(i), w_q[i]);
    end
    $display("test fifo done");
  endtask

  task automatic t_psave();
    power_save_enable = 1'b1;
    wait_state(wmh_pkg::DS_PSAVE, 20);
    dtim_tick = 1'b1;
    @(negedge clk);
    dtim_tick = 1'b0;
    repeat (3) @(negedge clk);
    chk_state("quiet beacon", wmh_pkg::DS_PSAVE, power_state);
    traffic_queued = 1'b1;
    rx_busy = 1'b1;
    dtim_tick = 1'b1;
    @(negedge clk);
    dtim_tick = 1'b0;
    chk_state("beacon wake", wmh_pkg::DS_RX, power_state);
    traffic_queued = 1'b0;
    rx_busy = 1'b0;
    wait_state(wmh_pkg::DS_PSAVE, 10);
    tx_busy = 1'b1;
    wait_state(wmh_pkg::DS_TX, 10);
    tx_busy = 1'b0;
    power_save_enable = 1'b0;
    wait_state(wmh_pkg::DS_STANDBY, 10);
    $display("test power save done");
  endtask

  task automatic t_deep();
    bit ok;
    dev_load(8'h5A, ok);
    load_valid = 1'b0;
    power_up = 1'b0;
    wait_state(wmh_pkg::DS_DEEP, 10);
    chk("regulators off", 0, regulators_on);
    chk("cs in deep", 1, link.cs_n);
    dev_load(8'h33, ok);
    load_valid = 1'b0;
    chk("load in deep", 0, 8'(ok));
    power_up = 1'b1;
    wait_ready();
    wait_state(wmh_pkg::DS_STANDBY, 60);
    chk("stale attn", 0, attn_pending);
    $display("test deep off done");
  endtask

  initial begin
    rstn = 1'b0;
    {power_up, start, tx_valid, supply_ok, power_save_enable, dtim_tick} = 6'h00;
    {traffic_queued, rx_busy, tx_busy, load_valid} = 4'h0;
    len_m1 = 4'h0;
    tx_data = 8'h00;
    load_data = 8'h00;
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    t_startup();
    t_fifo();
    t_psave();
    t_deep();
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
